/* design/hwdt_cfg.svh */
// Offsets, field positions, reset values and counts of the watchdog.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef HWDT_CFG_SVH
`define HWDT_CFG_SVH

// Register indices; the byte address is four times the index
`define HWDT_SVC_IDX      8'ha6
`define HWDT_TSEL_IDX     8'ha7
`define HWDT_CFG_IDX      8'ha8
`define HWDT_STAT_IDX     8'ha9

// Unlock and service pair
`define HWDT_KEY_FIRST    8'h1e
`define HWDT_KEY_SECOND   8'he1

// Counter structure
`define HWDT_PRE_BITS     14
`define HWDT_CNT_BITS     7
`define HWDT_VAL_BITS     21
`define HWDT_PHASES       3'h6

// Reset pulse length in oscillator periods
`define HWDT_RST_PULSE    7'h60

// Field positions and reset values
`define HWDT_TSEL_RST     3'h0
`define HWDT_CFG_CLKSEL   0
`define HWDT_CFG_DBL      1
`define HWDT_STAT_EN      0
`define HWDT_STAT_ARMED   1
`define HWDT_STAT_PULSE   2
`define HWDT_STAT_CNT_LO  8

`endif

/* design/hwdt_pkg.sv */
// Types shared by the watchdog modules.
// Assumes hwdt_cfg.svh has been compiled ahead of it.
`include "hwdt_cfg.svh"

package hwdt_pkg;

    // Progress through the two-byte service pair
    typedef enum logic {
        UNLOCK_IDLE,
        UNLOCK_GOT_FIRST
    } hwdt_unlock_t;

    // Complete state of the tick generator
    typedef struct packed {
        logic       half;    // Toggles at oscillator rate
        logic [2:0] phase;   // Watchdog clocks within one prescaler tick
        logic       tick;    // One-cycle prescaler advance
    } hwdt_tick_t;

    // Complete state of the watchdog core and its bus slave
    typedef struct packed {
        hwdt_unlock_t                 unlock;
        logic                         enabled;
        logic [`HWDT_CNT_BITS-1:0]    cnt;
        logic [`HWDT_PRE_BITS-1:0]    pre;
        logic [2:0]                   tsel;
        logic                         clk_sel;
        logic                         dbl;
        logic                         pulse;
        logic [6:0]                   pulse_cnt;
        logic                         pready;
        logic                         pslverr;
        logic [31:0]                  prdata;
    } hwdt_state_t;

endpackage

/* design/hwdt_tick.sv */
// Tick generator: oscillator to watchdog clock, then one tick per six.
// Assumes the caller gates ticks for power-down and freezes with ce.
`timescale 1ns/100ps
`default_nettype none
`include "hwdt_cfg.svh"

module hwdt_tick (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic run,
    input  wire logic half_rate,
    output var  logic tick
);

    hwdt_pkg::hwdt_tick_t st_ff;   // Registered state
    hwdt_pkg::hwdt_tick_t nxt_st;  // Next state
    logic                 wclk_en; // One watchdog clock period elapses

    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        // A tick that meets power-down waits for the clocks to resume
        nxt_st.tick = st_ff.tick && !run;
        // Half rate advances only on every other oscillator cycle
        wclk_en = run && (!half_rate || st_ff.half);
        if (run) begin
            nxt_st.half = !st_ff.half;
        end
        if (wclk_en) begin
            // Six watchdog clocks give the factor in front of the formula
            if (st_ff.phase == `HWDT_PHASES - 3'h1) begin
                nxt_st.phase = 3'h0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.phase = st_ff.phase + 3'h1;
            end
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

    phase_range_a: assert property (@(posedge clk) disable iff (srst)
        st_ff.phase < `HWDT_PHASES)
        else $error("Tick phase out of range");

    half_spacing_a: assert property (@(posedge clk) disable iff (srst)
        (ce && st_ff.tick && half_rate && run) |=> !st_ff.tick)
        else $error("Half rate tick came too soon");

endmodule // hwdt_tick

`default_nettype wire

/* design/hwdt_top.sv */
// Watchdog core with an APB register slave and chip reset pulse output.
// Assumes SYS_CLK is the oscillator and SRST is the chip reset.
`timescale 1ns/100ps
`default_nettype none
`include "hwdt_cfg.svh"

module hwdt_top (
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic        CE,
    input  wire logic        POWER_DOWN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    output var  logic        CHIP_RST,
    output var  logic        WDT_ENABLED
);

    hwdt_pkg::hwdt_state_t st_ff;   // Registered state
    hwdt_pkg::hwdt_state_t nxt_st;  // Next state
    logic                  tick;    // Prescaler advance from divider
    logic                  run;     // Watchdog clock running
    logic                  commit;  // APB access completes this edge
    logic                  svc_wr;  // Write to the service register
    logic [7:0]            wbyte;   // Low byte of write data
    logic [`HWDT_VAL_BITS-1:0] val;     // Prescaler and counter joined
    logic [`HWDT_VAL_BITS-1:0] nxt_val; // Value after one tick
    logic                  ovf;     // Timeout reached this cycle
    logic                  mapped;  // Address hits a register
    logic [31:0]           rd_word; // Read data for the current address

    // Byte address of a register index
    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'b00, idx, 2'b00};
    endfunction

    // Terminal value for a timeout select; n = 7 uses all 21 bits
    // Shifting a mask keeps one comparator for all eight selects
    function automatic logic [`HWDT_VAL_BITS-1:0] term(input logic [2:0] n);
        term = ~({`HWDT_VAL_BITS{1'b1}} << (`HWDT_PRE_BITS + int'(n)));
    endfunction

    // Power-down stops all phase clocks; idle does not stop us
    assign run = st_ff.enabled && !POWER_DOWN;

    hwdt_tick u_tick (
        .clk       (SYS_CLK),
        .srst      (SRST),
        .ce        (CE),
        .run       (run),
        .half_rate (st_ff.clk_sel || !st_ff.dbl),
        .tick      (tick)
    );

    // Bus decode and read mux
    always_comb begin
        commit = PSEL && PENABLE && st_ff.pready;
        wbyte = PWDATA[7:0];
        svc_wr = commit && PWRITE && (PADDR == reg_addr(`HWDT_SVC_IDX));
        mapped = 1'b1;
        rd_word = 32'h0;
        case (PADDR)
            reg_addr(`HWDT_SVC_IDX): begin
                // Write-only: reads give zero, not the last byte
                rd_word = 32'h0;
            end
            reg_addr(`HWDT_TSEL_IDX): begin
                // Reserved bits read as zero
                rd_word = {29'h0, st_ff.tsel};
            end
            reg_addr(`HWDT_CFG_IDX): begin
                rd_word[`HWDT_CFG_CLKSEL] = st_ff.clk_sel;
                rd_word[`HWDT_CFG_DBL] = st_ff.dbl;
            end
            reg_addr(`HWDT_STAT_IDX): begin
                rd_word[`HWDT_STAT_EN] = st_ff.enabled;
                rd_word[`HWDT_STAT_ARMED] =
                    (st_ff.unlock == hwdt_pkg::UNLOCK_GOT_FIRST);
                rd_word[`HWDT_STAT_PULSE] = st_ff.pulse;
                rd_word[`HWDT_STAT_CNT_LO +: `HWDT_CNT_BITS] = st_ff.cnt;
            end
            default: begin
                // Unmapped address answers with an error
                mapped = 1'b0;
            end
        endcase
    end

    // Counter arithmetic
    always_comb begin
        val = {st_ff.cnt, st_ff.pre};
        nxt_val = val + `HWDT_VAL_BITS'(1);
        // Counting stops while power-down holds, even on a late tick
        ovf = tick && run && (nxt_val == term(st_ff.tsel));
    end

    // Next-state logic
    // Later statements win, so the service pair overrides a tick's count step, not its timeout pulse
    always_comb begin
        nxt_st = st_ff;

        // APB: one wait state, then the answer for one cycle
        if (PSEL && PENABLE && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !mapped;
            nxt_st.prdata = PWRITE ? 32'h0 : rd_word;
        end else begin
            nxt_st.pready = 1'b0;
            nxt_st.pslverr = 1'b0;
        end

        // Prescaler and counter advance on each tick
        if (tick && run) begin
            {nxt_st.cnt, nxt_st.pre} = ovf ? '0 : nxt_val;
        end

        // Overflow starts the chip reset pulse
        if (ovf) begin
            nxt_st.pulse = 1'b1;
            nxt_st.pulse_cnt = `HWDT_RST_PULSE - 7'h1;
        end else if (st_ff.pulse) begin
            if (st_ff.pulse_cnt == 7'h0) begin
                nxt_st.pulse = 1'b0;
            end else begin
                nxt_st.pulse_cnt = st_ff.pulse_cnt - 7'h1;
            end
        end

        // Register writes land on the completing edge
        if (commit && PWRITE) begin
            if (PADDR == reg_addr(`HWDT_TSEL_IDX)) begin
                nxt_st.tsel = PWDATA[2:0];
            end
            if (PADDR == reg_addr(`HWDT_CFG_IDX)) begin
                nxt_st.clk_sel = PWDATA[`HWDT_CFG_CLKSEL];
                nxt_st.dbl = PWDATA[`HWDT_CFG_DBL];
            end
        end

        // Service pair detection; no write ever clears enable
        if (svc_wr) begin
            if (st_ff.unlock == hwdt_pkg::UNLOCK_GOT_FIRST &&
                wbyte == `HWDT_KEY_SECOND) begin
                // Service beats a tick's count step in the same cycle, not its timeout pulse
                nxt_st.enabled = 1'b1;
                nxt_st.cnt = '0;
                nxt_st.pre = '0;
                nxt_st.unlock = hwdt_pkg::UNLOCK_IDLE;
            end else if (wbyte == `HWDT_KEY_FIRST) begin
                nxt_st.unlock = hwdt_pkg::UNLOCK_GOT_FIRST;
            end else begin
                // Stray value restarts detection, count untouched
                nxt_st.unlock = hwdt_pkg::UNLOCK_IDLE;
            end
        end
    end

    // State register; chip reset also covers power-down exit by reset
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            st_ff <= '0;
            st_ff.tsel <= `HWDT_TSEL_RST;
            st_ff.unlock <= hwdt_pkg::UNLOCK_IDLE;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    assign PRDATA = st_ff.prdata;
    assign PREADY = st_ff.pready;
    assign PSLVERR = st_ff.pslverr;
    assign CHIP_RST = st_ff.pulse;
    assign WDT_ENABLED = st_ff.enabled;

    // Length of the current reset pulse, for checking only
    // Kept out of the state struct since no function depends on it
    logic [7:0] pulse_len_ff;
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pulse_len_ff <= 8'h0;
        end else if (CE) begin
            pulse_len_ff <= st_ff.pulse ? pulse_len_ff + 8'h1 : 8'h0;
        end
    end

    // Checks below read st_ff directly where a port would only copy it.
    // Antecedents that span an edge, apart from those of reset_clears_a, unlock_pair_a,
    // overflow_pulse_a, stray_restart_a and tsel_readback_a, also require SRST low,
    // so a reset released in the same step as the check cannot raise a false alarm.
    reset_clears_a: assert property (@(posedge SYS_CLK)
        SRST |=> (!WDT_ENABLED && st_ff.cnt == '0 && st_ff.pre == '0))
        else $error("Reset did not clear and disable");

    unlock_pair_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && svc_wr && wbyte == `HWDT_KEY_SECOND &&
         st_ff.unlock == hwdt_pkg::UNLOCK_GOT_FIRST)
        |=> (WDT_ENABLED && st_ff.cnt == '0 && st_ff.pre == '0))
        else $error("Service pair did not clear and enable");

    enable_sticky_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (WDT_ENABLED && !SRST) |=> WDT_ENABLED)
        else $error("Watchdog left the enabled state");

    pulse_length_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && CHIP_RST && !ovf && st_ff.pulse_cnt == 7'h0)
        |-> pulse_len_ff == 8'h5f)
        else $error("Reset pulse not 96 periods");

    overflow_pulse_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && ovf) |=> (CHIP_RST && st_ff.cnt == '0 && st_ff.pre == '0))
        else $error("Timeout did not raise reset and clear");

    pd_freeze_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (POWER_DOWN && !SRST && !svc_wr)
        |=> ($stable(st_ff.cnt) && $stable(st_ff.pre)))
        else $error("Count moved during power-down");

    stray_restart_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && svc_wr && wbyte != `HWDT_KEY_FIRST && !(wbyte ==
         `HWDT_KEY_SECOND && st_ff.unlock == hwdt_pkg::UNLOCK_GOT_FIRST))
        |=> (st_ff.unlock == hwdt_pkg::UNLOCK_IDLE && $stable(st_ff.enabled)))
        else $error("Stray service byte did not restart detection");

    tsel_readback_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && PSEL && PENABLE && !PREADY && !PWRITE &&
         PADDR == reg_addr(`HWDT_TSEL_IDX))
        |=> (PREADY && PRDATA == {29'h0, st_ff.tsel}))
        else $error("Timeout select readback wrong");

    // A tick with no service or timeout moves the joined count by one
    count_step_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && !SRST && tick && run && !ovf && !svc_wr)
        |=> ({st_ff.cnt, st_ff.pre} == $past(nxt_val)))
        else $error("Count did not advance by one tick");

    // A disabled watchdog neither counts nor pulses the chip reset
    disabled_idle_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        !WDT_ENABLED |-> (st_ff.cnt == '0 && st_ff.pre == '0 && !CHIP_RST))
        else $error("Disabled watchdog counted or pulsed");

    // First key always arms, even when the pair is already armed
    first_key_arms_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && !SRST && svc_wr && wbyte == `HWDT_KEY_FIRST)
        |=> (st_ff.unlock == hwdt_pkg::UNLOCK_GOT_FIRST))
        else $error("First key did not arm the pair");

    // Service register reads give zero and keep no trace of writes
    service_reads_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && !SRST && PSEL && PENABLE && !PREADY && !PWRITE &&
         PADDR == reg_addr(`HWDT_SVC_IDX))
        |=> (PREADY && PRDATA == 32'h0))
        else $error("Service register read back data");

    // Only the three select bits of a timeout select write are kept
    tsel_write_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && !SRST && commit && PWRITE &&
         PADDR == reg_addr(`HWDT_TSEL_IDX))
        |=> (st_ff.tsel == 3'($past(PWDATA))))
        else $error("Timeout select write did not land");

    // Clock select and double speed land together from one write
    config_write_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && !SRST && commit && PWRITE &&
         PADDR == reg_addr(`HWDT_CFG_IDX))
        |=> ({st_ff.dbl, st_ff.clk_sel} == 2'($past(PWDATA))))
        else $error("Clock configuration write did not land");

    // Ready stands for one cycle only, however long the master waits
    ready_pulse_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        (CE && !SRST && PREADY) |=> !PREADY)
        else $error("Ready stood longer than one cycle");

    // An error is only ever reported together with ready
    error_ready_a: assert property (@(posedge SYS_CLK)
        disable iff (SRST)
        PSLVERR |-> PREADY)
        else $error("Error raised without ready");

endmodule // hwdt_top

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the watchdog: APB register tests and one timeout.
// Assumes hwdt_top with a one-wait-state APB slave on SYS_CLK.
`timescale 1ns/100ps
`default_nettype none
`include "hwdt_cfg.svh"

module tb_top;
    // Byte addresses, four times the register index
    localparam logic [11:0] A_SVC  = {2'h0, `HWDT_SVC_IDX, 2'h0};
    localparam logic [11:0] A_TSEL = {2'h0, `HWDT_TSEL_IDX, 2'h0};
    localparam logic [11:0] A_CFG  = {2'h0, `HWDT_CFG_IDX, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, `HWDT_STAT_IDX, 2'h0};
    localparam logic [11:0] A_BAD  = 12'h400;  // Unmapped

    logic        sys_clk;     // 25 MHz oscillator
    logic        srst;        // Chip reset
    logic        ce;          // Clock enable, low for one stretch
    logic        power_down;  // Power-down request
    logic        psel;        // APB select
    logic        penable;     // APB enable
    logic        pwrite;      // APB direction
    logic [11:0] paddr;       // APB address
    logic [31:0] pwdata;      // APB write data
    logic [31:0] prdata;      // APB read data
    logic        pready;      // APB ready
    logic        pslverr;     // APB error
    logic        chip_rst;    // Reset pulse out
    logic        wdt_en;      // Enabled flag
    int          num_errors;  // Mismatch count
    int          checks;      // Comparison count
    int          n;           // Cycle counter

    hwdt_top dut (
        .SYS_CLK    (sys_clk),
        .SRST       (srst),
        .CE         (ce),
        .POWER_DOWN (power_down),
        .PSEL       (psel),
        .PENABLE    (penable),
        .PWRITE     (pwrite),
        .PADDR      (paddr),
        .PWDATA     (pwdata),
        .PRDATA     (prdata),
        .PREADY     (pready),
        .PSLVERR    (pslverr),
        .CHIP_RST   (chip_rst),
        .WDT_ENABLED(wdt_en)
    );

    // Clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One APB transfer; ready, data and error are taken at the rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int w;
        w = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            w++;
        end while (pready !== 1'b1 && w < 64);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (w >= 64) chk("pready wait", 32'h1, 32'h0);
    endtask

    // Write expecting no error
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("write error", {31'h0, e}, 32'h0);
    endtask

    // Read and compare, masked
    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] m, input logic [31:0] x,
                      input logic ex);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r & m, x);
        chk("read error", {31'h0, e}, {31'h0, ex});
    endtask

    // Watchdog against hangs
    initial begin
        repeat (115000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        srst = 1'b1; ce = 1'b1; power_down = 1'b0; psel = 1'b0;
        penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        num_errors = 0; checks = 0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rd("status", A_STAT, 32'h7, 32'h0, 1'b0);
        rd("tsel", A_TSEL, 32'hff, 32'h0, 1'b0);
        wr(A_TSEL, 32'h5);
        rd("tsel", A_TSEL, 32'hff, 32'h5, 1'b0);
        wr(A_TSEL, 32'h0);
        rd("service", A_SVC, 32'hffffffff, 32'h0, 1'b0);
        rd("unmapped", A_BAD, 32'hffffffff, 32'h0, 1'b1);
        // Second key alone, then a broken pair
        wr(A_SVC, 32'he1);
        wr(A_SVC, 32'h1e);
        wr(A_SVC, 32'h55);
        wr(A_SVC, 32'he1);
        rd("status", A_STAT, 32'h7, 32'h0, 1'b0);
        // Good pair with an unrelated read in between
        wr(A_SVC, 32'h1e);
        rd("status", A_STAT, 32'h3, 32'h2, 1'b0);
        wr(A_SVC, 32'he1);
        rd("status", A_STAT, 32'h3, 32'h1, 1'b0);
        // Writes that might look like a disable
        wr(A_CFG, 32'h3);
        rd("config", A_CFG, 32'h3, 32'h3, 1'b0);
        wr(A_CFG, 32'h0);
        wr(A_SVC, 32'h0);
        rd("status", A_STAT, 32'h1, 32'h1, 1'b0);
        // Fastest clock, shortest timeout, fresh service
        wr(A_CFG, 32'h2);
        rd("config", A_CFG, 32'h3, 32'h2, 1'b0);
        wr(A_SVC, 32'h1e);
        wr(A_SVC, 32'he1);
        power_down <= 1'b1;
        repeat (1000) @(posedge sys_clk);
        chk("rst in pd", {31'h0, chip_rst}, 32'h0);
        power_down <= 1'b0;
        n = 0;
        while (chip_rst !== 1'b1 && n < 110000) begin
            @(negedge sys_clk);
            n++;
        end
        // Six times 16383 watchdog clocks, plus divider phase slack
        chk("timeout", {31'h0, (n >= 98280 && n <= 98320)}, 32'h1);
        // Ten edges with CE low stretch the rest of the pulse to 96
        @(posedge sys_clk);
        ce <= 1'b0;
        repeat (10) @(posedge sys_clk);
        ce <= 1'b1;
        n = 0;
        while (chip_rst === 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        chk("pulse len", n, 32'd96);
        chk("enabled", {31'h0, wdt_en}, 32'h1);
        // Power-down ended by a chip reset rather than an interrupt
        @(posedge sys_clk);
        power_down <= 1'b1;
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        power_down <= 1'b0;
        @(negedge sys_clk);
        chk("enabled", {31'h0, wdt_en}, 32'h0);
        rd("status", A_STAT, 32'h7fff, 32'h0, 1'b0);
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
